// >>> core/spio_pkg.sv
// Package for the shared-pin I/O port block: register map and carriers.
// Assumes an APB master with 32-bit data and byte addresses.
`default_nettype none
package spio_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PA_DATA = 8'h00;
    localparam logic [7:0] OFS_PA_DIR = 8'h04;
    localparam logic [7:0] OFS_PA_PULL = 8'h08;
    localparam logic [7:0] OFS_PA_WAKE = 8'h0c;
    localparam logic [7:0] OFS_PB_DATA = 8'h10;
    localparam logic [7:0] OFS_PB_DIR = 8'h14;
    localparam logic [7:0] OFS_PB_PULL = 8'h18;
    localparam logic [7:0] OFS_PC_DATA = 8'h1c;
    localparam logic [7:0] OFS_PC_DIR = 8'h20;
    localparam logic [7:0] OFS_PC_PULL = 8'h24;
    localparam logic [7:0] OFS_PC_SEG = 8'h28;
    localparam logic [7:0] OFS_CTRL = 8'h2c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_BUZ_EN = 0;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_EXT = 1;
    localparam int PA_CLEAR_BIT = 7;
    localparam logic [7:0] RST_DIR = 8'hff;   // 1 = input
    localparam logic [7:0] RST_PULL = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] PA_PULL_MASK = 8'h7f;
    localparam logic [5:0] PB_MASK = 6'h3f;

    // Static configuration options sampled by the block
    typedef struct packed {
        logic clear_on_pa7;    // PA7 is hardware clear input
        logic main_osc_pins;   // PA6/PA5 used by main oscillator
        logic slow_osc_pins;   // PA4/PA3 used by slow oscillator
    } spio_opt_t;

    // Signals routed to other on-chip functions
    typedef struct packed {
        logic [3:0] touch_key_inputs;
        logic ext_irq_in;
        logic timer0_event_in;
        logic timer1_event_in;
        logic timer2_event_in;
        logic hw_clear_input;
    } spio_alt_t;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ACCESS
    } spio_apb_st_t;
endpackage : spio_pkg
`default_nettype wire

// >>> core/spio_ports.sv
// Three shared-pin I/O ports with alternate functions and APB registers.
// Assumes pins are synchronous to sys_clk_in; pads resolve oe/out/pull.
//
// Operation
// RQ1: Per-bit wake enable on port A
// RQ2: Each pin push-pull output or input; PA7 drives low only (open drain)
// RQ3: Port A pull-ups, none on bit 7
// RQ4: PA7 open drain or input, never pull-up
// RQ5: Option selects PA7 as clear input
// RQ6: Control bit makes PA1/PA2 buzzer pair
// RQ7: Option gives PA6/PA5 to main oscillator
// RQ8: Option gives PA4/PA3 to slow oscillator
// RQ9: Port C bits selectable as LCD drives
// RQ10: Port C resets to input with pull-up
// RQ11: Port B shares touch, interrupt, timer0
// RQ12: PC0/PC1 feed timer1 and timer2 events
// RQ13: Data read gives pin or latch value
//
// Our own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module spio_ports
    import spio_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire spio_opt_t options_in,
    input wire logic buzzer_tone_in,
    input wire logic [7:0] lcd_drive_lines_in,
    input wire logic [7:0] port_a_bits_in,
    output logic [7:0] port_a_bits_out,
    output logic [7:0] port_a_bits_oe_out,
    output logic [7:0] port_a_pull_out,
    input wire logic [5:0] port_b_bits_in,
    output logic [5:0] port_b_bits_out,
    output logic [5:0] port_b_bits_oe_out,
    output logic [5:0] port_b_pull_out,
    input wire logic [7:0] port_c_bits_in,
    output logic [7:0] port_c_bits_out,
    output logic [7:0] port_c_bits_oe_out,
    output logic [7:0] port_c_pull_out,
    output logic [7:0] lcd_seg_en_out,
    output spio_alt_t alt_out,
    output logic wake_out,
    output logic irq_out
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] pa_latch, pa_dir, pa_pull, pa_wake;
    logic [5:0] pb_latch, pb_dir, pb_pull;
    logic [7:0] pc_latch, pc_dir, pc_pull, pc_seg;
    logic buz_en;
    logic [1:0] irq_stat, irq_mask;
    logic [7:0] pa_s1, pa_s2, pc_s1, pc_s2;
    logic [5:0] pb_s1, pb_s2;
    logic [7:0] pa_prev;
    logic pb4_prev;
    logic [31:0] next_rdata;
    logic wr_acc, rd_acc, hit;
    logic [7:0] pa_io, pa_read, pc_read;
    logic [5:0] pb_read;
    logic wake_ev, ext_ev;

    function automatic logic [7:0] read_mix(input logic [7:0] dir,
        input logic [7:0] latch, input logic [7:0] pin);
        read_mix = (dir & pin) | (~dir & latch);
    endfunction : read_mix

    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign rd_acc = psel_in & ~pwrite_in;
    assign pready_out = 1'b1;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            // Idle high, so no false clear pulse after reset
            pa_s1 <= RST_PULL;
            pa_s2 <= RST_PULL;
            pb_s1 <= 6'h00;
            pb_s2 <= 6'h00;
            pc_s1 <= RST_ZERO;
            pc_s2 <= RST_ZERO;
        end else begin
            pa_s1 <= port_a_bits_in;
            pa_s2 <= pa_s1;
            pb_s1 <= port_b_bits_in;
            pb_s2 <= pb_s1;
            pc_s1 <= port_c_bits_in;
            pc_s2 <= pc_s1;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pa_latch <= RST_ZERO;
            pa_dir <= RST_DIR;
            pa_pull <= RST_ZERO;
            pa_wake <= RST_ZERO;
            pb_latch <= 6'h00;
            pb_dir <= PB_MASK;
            pb_pull <= 6'h00;
            pc_latch <= RST_ZERO;
            pc_dir <= RST_DIR;          // [RQ10]
            pc_pull <= RST_PULL;        // [RQ10]
            pc_seg <= RST_ZERO;         // [RQ10]
            buz_en <= 1'b0;
            irq_mask <= 2'b00;
        end else if (wr_acc) begin
            unique case (paddr_in)
                OFS_PA_DATA: pa_latch <= pwdata_in[7:0];
                OFS_PA_DIR: pa_dir <= pwdata_in[7:0];           // [RQ2]
                OFS_PA_PULL: pa_pull <= pwdata_in[7:0] & PA_PULL_MASK; // [RQ3]
                OFS_PA_WAKE: pa_wake <= pwdata_in[7:0];         // [RQ1]
                OFS_PB_DATA: pb_latch <= pwdata_in[5:0];
                OFS_PB_DIR: pb_dir <= pwdata_in[5:0];           // [RQ2]
                OFS_PB_PULL: pb_pull <= pwdata_in[5:0];
                OFS_PC_DATA: pc_latch <= pwdata_in[7:0];
                OFS_PC_DIR: pc_dir <= pwdata_in[7:0];           // [RQ2]
                OFS_PC_PULL: pc_pull <= pwdata_in[7:0];
                OFS_PC_SEG: pc_seg <= pwdata_in[7:0];           // [RQ9]
                OFS_CTRL: buz_en <= pwdata_in[CTRL_BUZ_EN];     // [RQ6]
                OFS_IRQ_MASK: irq_mask <= pwdata_in[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wake and external interrupt events
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pa_prev <= RST_PULL;
            pb4_prev <= 1'b0;
        end else begin
            pa_prev <= pa_s2;
            pb4_prev <= pb_s2[4];
        end
    end

    // Change on an enabled input pin of port A
    assign wake_ev = |((pa_s2 ^ pa_prev) & pa_wake & pa_dir & pa_io); // [RQ1]
    assign ext_ev = pb4_prev & ~pb_s2[4] & pb_dir[4];

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            irq_stat <= 2'b00;
        end else begin
            // Set wins over a write-one clear
            irq_stat[IRQ_WAKE] <= wake_ev | (irq_stat[IRQ_WAKE] &
                ~(wr_acc && paddr_in == OFS_IRQ_STAT && pwdata_in[IRQ_WAKE]));
            irq_stat[IRQ_EXT] <= ext_ev | (irq_stat[IRQ_EXT] &
                ~(wr_acc && paddr_in == OFS_IRQ_STAT && pwdata_in[IRQ_EXT]));
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat & irq_mask);
            wake_out <= wake_ev;                                // [RQ1]
        end
    end

    // ------------------------------------------------------------------
    // Pin ownership and drivers
    // ------------------------------------------------------------------
    always_comb begin
        pa_io = 8'hff;
        if (options_in.main_osc_pins) begin
            pa_io[6] = 1'b0;                                    // [RQ7]
            pa_io[5] = 1'b0;                                    // [RQ7]
        end
        if (options_in.slow_osc_pins) begin
            pa_io[4] = 1'b0;                                    // [RQ8]
            pa_io[3] = 1'b0;                                    // [RQ8]
        end
        if (options_in.clear_on_pa7) begin
            pa_io[PA_CLEAR_BIT] = 1'b0;                         // [RQ5]
        end
    end

    always_comb begin
        port_a_bits_out = pa_latch;
        port_a_bits_oe_out = ~pa_dir & pa_io;                   // [RQ2]
        if (buz_en) begin
            port_a_bits_out[1] = buzzer_tone_in;                // [RQ6]
            port_a_bits_out[2] = ~buzzer_tone_in;               // [RQ6]
            port_a_bits_oe_out[1] = pa_io[1];
            port_a_bits_oe_out[2] = pa_io[2];
        end
        // Open drain: drive only low
        port_a_bits_out[7] = 1'b0;                              // [RQ4]
        port_a_bits_oe_out[7] = pa_io[7] & ~pa_dir[7] & ~pa_latch[7]; // [RQ4]
        port_a_pull_out = pa_pull & pa_dir & pa_io & PA_PULL_MASK; // [RQ3]
    end

    assign port_b_bits_out = pb_latch;
    assign port_b_bits_oe_out = ~pb_dir;                        // [RQ2]
    assign port_b_pull_out = pb_pull & pb_dir;
    assign port_c_bits_out = (pc_latch & ~pc_seg)
        | (lcd_drive_lines_in & pc_seg);
    assign port_c_bits_oe_out = (~pc_dir & ~pc_seg) | pc_seg;   // [RQ9]
    assign port_c_pull_out = pc_pull & pc_dir & ~pc_seg;        // [RQ9]
    assign lcd_seg_en_out = pc_seg;

    // ------------------------------------------------------------------
    // Alternate function routing
    // ------------------------------------------------------------------
    always_comb begin
        alt_out.touch_key_inputs = pb_s2[3:0];                  // [RQ11]
        alt_out.ext_irq_in = pb_s2[4];                          // [RQ11]
        alt_out.timer0_event_in = pb_s2[5];                     // [RQ11]
        alt_out.timer1_event_in = pc_s2[0] & ~pc_seg[0];        // [RQ12]
        alt_out.timer2_event_in = pc_s2[1] & ~pc_seg[1];        // [RQ12]
        alt_out.hw_clear_input = options_in.clear_on_pa7 & ~pa_s2[7]; // [RQ5]
    end

    // ------------------------------------------------------------------
    // APB read
    // ------------------------------------------------------------------
    assign pa_read = read_mix(pa_dir, pa_latch, pa_s2);         // [RQ13]
    assign pb_read = 6'(read_mix({2'b00, pb_dir}, {2'b00, pb_latch},
        {2'b00, pb_s2}));                                       // [RQ13]
    assign pc_read = read_mix(pc_dir | pc_seg, pc_latch, pc_s2 & ~pc_seg);

    always_comb begin
        next_rdata = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr_in)
            OFS_PA_DATA: next_rdata[7:0] = pa_read;
            OFS_PA_DIR: next_rdata[7:0] = pa_dir;
            OFS_PA_PULL: next_rdata[7:0] = pa_pull;
            OFS_PA_WAKE: next_rdata[7:0] = pa_wake;
            OFS_PB_DATA: next_rdata[5:0] = pb_read;
            OFS_PB_DIR: next_rdata[5:0] = pb_dir;
            OFS_PB_PULL: next_rdata[5:0] = pb_pull;
            OFS_PC_DATA: next_rdata[7:0] = pc_read;
            OFS_PC_DIR: next_rdata[7:0] = pc_dir;
            OFS_PC_PULL: next_rdata[7:0] = pc_pull;
            OFS_PC_SEG: next_rdata[7:0] = pc_seg;
            OFS_CTRL: next_rdata[CTRL_BUZ_EN] = buz_en;
            OFS_IRQ_STAT: next_rdata[1:0] = irq_stat;
            OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (rd_acc && !penable_in) begin
            prdata_out <= next_rdata;
        end
    end

    assign pslverr_out = psel_in & penable_in & ~hit;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr(logic [7:0] a);
        psel_in && penable_in && pwrite_in && paddr_in == a;
    endsequence

    property p_wake;
        @(posedge sys_clk_in) disable iff (srst_in)
        wake_ev |=> wake_out && irq_stat[IRQ_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("wake lost"); // [RQ1]

    property p_dir;
        @(posedge sys_clk_in) disable iff (srst_in)
        s_wr(OFS_PB_DIR) |=> port_b_bits_oe_out == ~$past(pwdata_in[5:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("dir not applied"); // [RQ2]

    property p_pa_pull;
        @(posedge sys_clk_in) disable iff (srst_in)
        !port_a_pull_out[7];
    endproperty
    a_pa_pull: assert property (p_pa_pull) else $error("pa7 pull"); // [RQ3]

    property p_od;
        @(posedge sys_clk_in) disable iff (srst_in)
        port_a_bits_oe_out[7] |-> !port_a_bits_out[7] && !pa_latch[7];
    endproperty
    a_od: assert property (p_od) else $error("pa7 drives high"); // [RQ4]

    property p_clr;
        @(posedge sys_clk_in) disable iff (srst_in)
        options_in.clear_on_pa7 |-> !port_a_bits_oe_out[7];
    endproperty
    a_clr: assert property (p_clr) else $error("pa7 driven"); // [RQ5]

    property p_buz;
        @(posedge sys_clk_in) disable iff (srst_in)
        buz_en |-> port_a_bits_out[1] == buzzer_tone_in
            && port_a_bits_out[2] == !buzzer_tone_in;
    endproperty
    a_buz: assert property (p_buz) else $error("buzzer pair"); // [RQ6]

    property p_osc;
        @(posedge sys_clk_in) disable iff (srst_in)
        options_in.main_osc_pins |-> port_a_bits_oe_out[6:5] == 2'b00
            && port_a_pull_out[6:5] == 2'b00;
    endproperty
    a_osc: assert property (p_osc) else $error("osc pins driven"); // [RQ7]

    property p_seg;
        @(posedge sys_clk_in) disable iff (srst_in)
        s_wr(OFS_PC_SEG) |=> (port_c_pull_out & $past(pwdata_in[7:0]))
            == 8'h00;
    endproperty
    a_seg: assert property (p_seg) else $error("seg pull"); // [RQ9]

    property p_rst;
        @(posedge sys_clk_in) $fell(srst_in) |->
            port_c_bits_oe_out == 8'h00 && port_c_pull_out == 8'hff;
    endproperty
    a_rst: assert property (p_rst) else $error("pc reset"); // [RQ10]

    property p_rd;
        @(posedge sys_clk_in) disable iff (srst_in)
        (psel_in && !penable_in && !pwrite_in && paddr_in == OFS_PA_DATA)
            |=> prdata_out[7:0] == $past(pa_read);
    endproperty
    a_rd: assert property (p_rd) else $error("data read"); // [RQ13]
endmodule : spio_ports
`default_nettype wire

// >>> verification/spio_board.sv
// Board model: resolves one port's pins from pad drive, pulls and stimulus.
// Assumes the bench sets a per-pin drive enable and value on rising edges.
`default_nettype none
module spio_board #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] out_in,
    input wire logic [W-1:0] pull_in,
    input wire logic [W-1:0] drv_en_in,
    input wire logic [W-1:0] drv_val_in,
    output logic [W-1:0] level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;

    // Floating pins change every cycle
    always_ff @(posedge clk_in) begin
        flip <= ~flip;
    end

    // Pad wins, then board, then pull-up, else floating
    always_comb begin
        level_out = (oe_in & out_in)
            | (~oe_in & drv_en_in & drv_val_in)
            | (~oe_in & ~drv_en_in & pull_in)
            | (~oe_in & ~drv_en_in & ~pull_in & {W{flip}});
    end
endmodule : spio_board
`default_nettype wire

// >>> verification/spio_ports_tb_top.sv
// Bench for spio_ports: APB tasks and scripted register and pin checks.
// Assumes spio_board models the pins of every port.
`default_nettype none
module spio_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spio_pkg::*;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, hit, wake, irq;
    spio_opt_t opts = '0;
    logic tone = 1'b0;
    logic [7:0] lcd = 8'ha5;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pull, pc_in, pc_out, pc_oe, pc_pull;
    logic [5:0] pb_in, pb_out, pb_oe, pb_pull;
    logic [7:0] seg_en;
    spio_alt_t alt;
    logic [7:0] pa_dv = 8'hff;
    logic [5:0] pb_dv = 6'h3f;
    logic [5:0] pb_de = 6'h3f;
    logic [7:0] pc_de = 8'h00;
    logic [7:0] pc_dv = 8'h00;
    logic [1:0] tim_ev;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    spio_ports dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .options_in(opts),
        .buzzer_tone_in(tone), .lcd_drive_lines_in(lcd),
        .port_a_bits_in(pa_in), .port_a_bits_out(pa_out),
        .port_a_bits_oe_out(pa_oe), .port_a_pull_out(pa_pull),
        .port_b_bits_in(pb_in), .port_b_bits_out(pb_out),
        .port_b_bits_oe_out(pb_oe), .port_b_pull_out(pb_pull),
        .port_c_bits_in(pc_in), .port_c_bits_out(pc_out),
        .port_c_bits_oe_out(pc_oe), .port_c_pull_out(pc_pull),
        .lcd_seg_en_out(seg_en), .alt_out(alt), .wake_out(wake),
        .irq_out(irq));
    spio_board #(.W(8)) u_pa (.clk_in(sys_clk_in), .oe_in(pa_oe),
        .out_in(pa_out), .pull_in(pa_pull), .drv_en_in(8'hff),
        .drv_val_in(pa_dv), .level_out(pa_in));
    spio_board #(.W(6)) u_pb (.clk_in(sys_clk_in), .oe_in(pb_oe),
        .out_in(pb_out), .pull_in(pb_pull), .drv_en_in(pb_de),
        .drv_val_in(pb_dv), .level_out(pb_in));
    spio_board #(.W(8)) u_pc (.clk_in(sys_clk_in), .oe_in(pc_oe),
        .out_in(pc_out), .pull_in(pc_pull), .drv_en_in(pc_de),
        .drv_val_in(pc_dv), .level_out(pc_in));
    assign tim_ev = {alt.timer1_event_in, alt.timer2_event_in};

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        @(posedge sys_clk_in);
        while (pready !== 1'b1) @(posedge sys_clk_in);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    task automatic wait_wake();
        hit = 1'b0;
        repeat (10) begin
            settle(1);
            if (wake === 1'b1) hit = 1'b1;
        end
    endtask : wait_wake

    // ------------------------------------------------------------------
    // Clock, timeout and scenarios
    // ------------------------------------------------------------------
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        settle(1);
        chk("pc_pull", 32'hff, pc_pull);
        chk("pc_oe", 32'h0, pc_oe);
        chk("seg_en", 32'h0, seg_en);
        rdchk("pa_dir", OFS_PA_DIR, 32'hff);
        rdchk("pc_pull_reg", OFS_PC_PULL, 32'hff);
        rdchk("pc_seg_reg", OFS_PC_SEG, 32'h0);
        wr(OFS_PA_DIR, 32'h0);
        wr(OFS_PA_DATA, 32'h55);
        settle(1);
        chk("pa_oe", 32'hff, pa_oe);
        chk("pa_out", 32'h55, pa_out);
        rdchk("pa_data", OFS_PA_DATA, 32'h55);
        wr(OFS_PA_DATA, 32'hd5);
        settle(1);
        chk("pa_oe_od", 32'h7f, pa_oe);
        chk("pa_out_od", 32'h55, pa_out);
        wr(OFS_PA_DIR, 32'hff);
        wr(OFS_PA_PULL, 32'hff);
        rdchk("pa_pull_reg", OFS_PA_PULL, 32'h7f);
        chk("pa_pull", 32'h7f, pa_pull);
        @(posedge sys_clk_in);
        pa_dv <= 8'h3c;
        settle(4);
        rdchk("pa_pin", OFS_PA_DATA, 32'h3c);
        wr(OFS_PA_WAKE, 32'h01);
        wr(OFS_IRQ_STAT, 32'h3);
        pa_dv <= 8'h3d;
        wait_wake();
        chk("wake_on", 32'h1, hit);
        @(posedge sys_clk_in);
        pa_dv <= 8'h3f;
        wait_wake();
        chk("wake_off", 32'h0, hit);
        rdchk("stat_wake", OFS_IRQ_STAT, 32'h1);
        wr(OFS_IRQ_MASK, 32'h2);
        pb_dv <= 6'h2f;
        settle(6);
        chk("irq_on", 32'h1, irq);
        rdchk("stat_ext", OFS_IRQ_STAT, 32'h3);
        wr(OFS_IRQ_STAT, 32'h2);
        settle(2);
        chk("irq_clr", 32'h0, irq);
        rdchk("stat_w1c", OFS_IRQ_STAT, 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        pb_dv <= 6'h3f;
        settle(3);
        @(posedge sys_clk_in);
        pb_dv <= 6'h2a;
        settle(6);
        chk("irq_masked", 32'h0, irq);
        rdchk("stat_masked", OFS_IRQ_STAT, 32'h3);
        chk("touch", 32'ha, {28'h0, alt.touch_key_inputs});
        chk("int_t0", 32'h1, {alt.ext_irq_in, alt.timer0_event_in});
        wr(OFS_IRQ_STAT, 32'h3);
        wr(OFS_PA_DIR, 32'h0);
        wr(OFS_PA_DATA, 32'h0);
        wr(OFS_CTRL, 32'h1);
        tone <= 1'b1;
        settle(2);
        chk("buz_hi", 32'h1, pa_out[2:1]);
        chk("buz_oe", 32'h3, pa_oe[2:1]);
        @(posedge sys_clk_in);
        tone <= 1'b0;
        settle(2);
        chk("buz_lo", 32'h2, pa_out[2:1]);
        wr(OFS_CTRL, 32'h0);
        settle(1);
        chk("buz_off", 32'h0, pa_out[2:1]);
        chk("tim_ev", 32'h3, tim_ev);
        wr(OFS_PC_SEG, 32'h03);
        settle(4);
        chk("seg_en_set", 32'h03, seg_en);
        chk("seg_pull", 32'hfc, pc_pull);
        chk("seg_drv", 32'h1, pc_out[1:0]);
        chk("tim_ev_seg", 32'h0, tim_ev);
        rdchk("pc_data_seg", OFS_PC_DATA, 32'hfc);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmap_data", 32'h0, rd);
        chk("unmap_err", 32'h1, er);
        @(posedge sys_clk_in);
        opts <= '1;
        settle(2);
        chk("opt_oe", 32'h07, pa_oe);
        wr(OFS_PA_DIR, 32'hff);
        settle(1);
        chk("opt_pull", 32'h07, pa_pull);
        @(posedge sys_clk_in);
        pa_dv <= 8'h7f;
        settle(4);
        chk("clr_on", 32'h1, alt.hw_clear_input);
        @(posedge sys_clk_in);
        opts <= '0;
        settle(4);
        chk("clr_off", 32'h0, alt.hw_clear_input);
        wr(OFS_PC_SEG, 32'h0);
        wr(OFS_PC_DIR, 32'h0f);
        wr(OFS_PC_DATA, 32'ha0);
        pc_de <= 8'h0f;
        pc_dv <= 8'h05;
        settle(4);
        chk("pc_oe_io", 32'hf0, pc_oe);
        chk("pc_out_io", 32'ha0, pc_out);
        chk("tim_ev_pin", 32'h2, tim_ev);
        rdchk("pc_data_mix", OFS_PC_DATA, 32'ha5);
        wr(OFS_PB_PULL, 32'h3f);
        wr(OFS_PB_DIR, 32'h0c);
        wr(OFS_PB_DATA, 32'h31);
        pb_de <= 6'h00;
        settle(4);
        chk("pb_oe", 32'h33, pb_oe);
        chk("pb_out", 32'h31, pb_out);
        chk("pb_pull", 32'h0c, pb_pull);
        rdchk("pb_data_mix", OFS_PB_DATA, 32'h3d);
        end_of_test();
    end
endmodule : spio_ports_tb_top
`default_nettype wire
